// >>> src/spp_pkg.sv
package spp_pkg;
    // register word indices; byte address = FRAME_BASE + index * 4
    localparam logic [3:0] IDX_CONFIG  = 4'h0;
    localparam logic [3:0] IDX_CONTROL = 4'h1;
    localparam logic [3:0] IDX_STATUS  = 4'h2;
    localparam logic [3:0] IDX_MASK    = 4'h3;
    localparam logic [3:0] IDX_RATE    = 4'h4;
    localparam logic [3:0] IDX_RXLO    = 4'h6;
    localparam logic [3:0] IDX_RXHI    = 4'h7;
    localparam logic [3:0] IDX_TXLO    = 4'h8;
    localparam logic [3:0] IDX_TXHI    = 4'h9;
    localparam logic [3:0] IDX_GAP     = 4'hA;
    localparam logic [3:0] IDX_LEVEL   = 4'hB;
    localparam logic [15:0] FRAME_BASE = 16'h7040;
    localparam int          DATA_W     = 8;
    localparam int          WORD_W     = 16;
    localparam int          QDEPTH     = 4;
    // config fields
    localparam int CFG_LEN_LSB  = 0;
    localparam int CFG_POL_BIT  = 6;
    localparam int CFG_MAST_BIT = 7;
    // control fields
    localparam int CTL_EN_BIT    = 0;
    localparam int CTL_TXEN_BIT  = 1;
    localparam int CTL_PHA_BIT   = 2;
    localparam int CTL_3W_BIT    = 3;
    // status / mask bits
    localparam int ST_RXDONE = 0;
    localparam int ST_TXEMPTY = 1;
    localparam int ST_OVERRUN = 2;
    localparam logic [7:0] RST_CONFIG = 8'h0F;
    localparam logic [7:0] RST_RATE   = 8'h03;
    localparam logic [6:0] RATE_MIN   = 7'h03;
    localparam logic [7:0] MIN_DIV    = 8'h04;
endpackage

// >>> src/spp_q_if.sv
`timescale 1ns/100ps
interface spp_q_if;
    logic        wr;
    logic [15:0] wdata;
    logic        rd;
    logic [15:0] rdata;
    logic        empty;
    logic        full;
    logic [2:0]  level;
    modport owner (output wr, output wdata, output rd,
                   input rdata, input empty, input full, input level);
    modport queue (input wr, input wdata, input rd,
                   output rdata, output empty, output full, output level);
endinterface

// >>> src/spp_queue.sv
`timescale 1ns/100ps
module spp_queue (
    input  wire logic clk,
    input  wire logic rst_n,
    spp_q_if.queue    q
);
    logic [15:0] mem_q [spp_pkg::QDEPTH];
    logic [1:0]  wp_q;
    logic [1:0]  rp_q;
    logic [2:0]  cnt_q;
    logic        do_wr;
    logic        do_rd;

    assign do_wr   = q.wr && (cnt_q != 3'(spp_pkg::QDEPTH));
    assign do_rd   = q.rd && (cnt_q != 3'h0);
    assign q.empty = (cnt_q == 3'h0);
    assign q.full  = (cnt_q == 3'(spp_pkg::QDEPTH));
    assign q.level = cnt_q;
    assign q.rdata = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wp_q] <= q.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= 2'h0;
            rp_q  <= 2'h0;
            cnt_q <= 3'h0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 2'h1;
            end
            if (do_rd) begin
                rp_q <= rp_q + 2'h1;
            end
            cnt_q <= cnt_q + 3'(do_wr) - 3'(do_rd);
        end
    end
endmodule // spp_queue

// >>> src/spp_top.sv
`timescale 1ns/100ps
module spp_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_b,
    input  wire logic        slave_in_master_out_pin_i,
    output logic             slave_in_master_out_pin_o,
    output logic             slave_in_master_out_pin_oe_b,
    input  wire logic        slave_out_master_in_pin_i,
    output logic             slave_out_master_in_pin_o,
    output logic             slave_out_master_in_pin_oe_b,
    input  wire logic        slave_select_pin_i,
    output logic             slave_select_pin_o,
    output logic             slave_select_pin_oe_b
);
    typedef enum logic [1:0] {SPP_IDLE, SPP_GAP, SPP_SHIFT} spp_state_e;

    logic        rs1_q, rst_n;
    logic [7:0]  cfg_q, ctl_q, mask_q, rate_q, gap_q, stat_q;
    logic [7:0]  txlo_q, rxhi_q;
    logic [7:0]  div_cnt_q;
    logic        half_en;
    logic        sck_q, sck_prev_q;
    logic [15:0] sh_q;
    logic [4:0]  bit_q;
    logic        phase_q;
    logic [7:0]  gap_cnt_q;
    spp_state_e  st_q;
    logic        acc, wr_acc, rd_acc;
    logic [3:0]  idx;
    logic        hit;
    logic [7:0]  rd_val;
    logic        rx_push, tx_pop, done_ev, ovr_ev;
    logic        master, pol, pha, en, txen, three;
    logic [4:0]  len;
    logic        sel_act, sclk_in, s_rise, s_fall, lead_edge, trail_edge;
    logic        mosi_in, miso_in, rx_bit;
    logic [15:0] rx_word;
    logic [7:0]  st_set;

    spp_q_if txq ();
    spp_q_if rxq ();
    spp_queue u_txq (.clk(clk), .rst_n(rst_n), .q(txq));
    spp_queue u_rxq (.clk(clk), .rst_n(rst_n), .q(rxq));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    assign master = cfg_q[spp_pkg::CFG_MAST_BIT];
    assign pol    = cfg_q[spp_pkg::CFG_POL_BIT];
    assign len    = {1'b0, cfg_q[spp_pkg::CFG_LEN_LSB +: 4]} + 5'h01;
    assign en     = ctl_q[spp_pkg::CTL_EN_BIT];
    assign txen   = ctl_q[spp_pkg::CTL_TXEN_BIT];
    assign pha    = ctl_q[spp_pkg::CTL_PHA_BIT];
    assign three  = ctl_q[spp_pkg::CTL_3W_BIT];

    // apb decode, frame base plus word index times four
    assign acc    = psel && penable;
    assign idx    = paddr[5:2];
    assign hit    = (paddr[15:6] == spp_pkg::FRAME_BASE[15:6]);
    assign wr_acc = acc && pwrite && hit;
    assign rd_acc = acc && !pwrite && hit;

    always_comb begin
        rd_val = 8'h00;
        case (idx)
            spp_pkg::IDX_CONFIG:  rd_val = cfg_q;
            spp_pkg::IDX_CONTROL: rd_val = ctl_q;
            spp_pkg::IDX_STATUS:  rd_val = stat_q;
            spp_pkg::IDX_MASK:    rd_val = mask_q;
            spp_pkg::IDX_RATE:    rd_val = rate_q;
            spp_pkg::IDX_RXLO:    rd_val = rxq.rdata[7:0];
            spp_pkg::IDX_RXHI:    rd_val = rxhi_q;
            spp_pkg::IDX_TXLO:    rd_val = txlo_q;
            spp_pkg::IDX_GAP:     rd_val = gap_q;
            spp_pkg::IDX_LEVEL:   rd_val = {1'b0, txq.level, 1'b0, rxq.level};
            default:              rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !pready;
            pslverr <= psel && !pready && !hit;
            // upper bits always read zero
            prdata  <= (psel && !pready && hit) ? {24'h000000, rd_val}
                                                : 32'h0;
        end
    end

    logic ap;
    assign ap = acc && pready;

    // upper write bits discarded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q  <= spp_pkg::RST_CONFIG;
            ctl_q  <= 8'h00;
            mask_q <= 8'h00;
            rate_q <= spp_pkg::RST_RATE;
            gap_q  <= 8'h00;
            txlo_q <= 8'h00;
        end else if (ap && wr_acc) begin
            case (idx)
                spp_pkg::IDX_CONFIG:  cfg_q  <= pwdata[7:0];
                spp_pkg::IDX_CONTROL: ctl_q  <= pwdata[7:0];
                spp_pkg::IDX_MASK:    mask_q <= pwdata[7:0];
                spp_pkg::IDX_RATE:    rate_q <= {1'b0, pwdata[6:0]};
                spp_pkg::IDX_GAP:     gap_q  <= pwdata[7:0];
                spp_pkg::IDX_TXLO:    txlo_q <= pwdata[7:0];
                default:              ;
            endcase
        end
    end

    // writing the high byte pushes a word; left-aligned for msb first
    assign txq.wr    = ap && wr_acc && (idx == spp_pkg::IDX_TXHI);
    assign txq.wdata = {pwdata[7:0], txlo_q};
    // reading low byte latches high byte and pops the word
    assign rxq.rd    = ap && rd_acc && (idx == spp_pkg::IDX_RXLO);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxhi_q <= 8'h00;
        end else if (rxq.rd) begin
            rxhi_q <= rxq.rdata[15:8];
        end
    end

    // half-bit enable: divider+1 clocks per bit, minimum four
    function automatic logic [7:0] bit_div(input logic [7:0] r);
        bit_div = (r[6:0] < spp_pkg::RATE_MIN) ? spp_pkg::MIN_DIV
                                               : ({1'b0, r[6:0]} + 8'h01);
    endfunction

    logic [7:0] bdiv;
    logic [7:0] hpoint;
    assign bdiv   = bit_div(rate_q);
    assign hpoint = {1'b0, bdiv[7:1]};

    logic run;
    assign run = (st_q == SPP_SHIFT) && master;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 8'h00;
        end else if (!run || div_cnt_q == bdiv - 8'h01) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    // odd divisors give the longer half to the trailing phase
    assign half_en = run && ((div_cnt_q == hpoint - 8'h01) ||
                             (div_cnt_q == bdiv - 8'h01));

    // master clock toggles; idle level equals polarity
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
        end else if (!run) begin
            sck_q <= pol;
        end else if (half_en) begin
            sck_q <= !sck_q;
        end
    end

    assign sclk_in = master ? sck_q : serial_clock_pin_i;
    assign sel_act = master || !slave_select_pin_i;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sclk_in;
        end
    end

    assign s_rise = sclk_in && !sck_prev_q;
    assign s_fall = !sclk_in && sck_prev_q;
    // leading edge leaves idle; sample on leading when delayed
    assign lead_edge  = pol ? s_fall : s_rise;
    assign trail_edge = pol ? s_rise : s_fall;

    // three-wire: master receives on its own out line
    assign mosi_in = slave_in_master_out_pin_i;
    assign miso_in = three ? mosi_in : slave_out_master_in_pin_i;
    assign rx_bit  = master ? miso_in : mosi_in;

    logic smp, lau;
    assign smp = pha ? lead_edge : trail_edge;
    assign lau = pha ? trail_edge : lead_edge;

    function automatic logic [15:0] ins(input logic [15:0] w,
                                        input logic b);
        ins = {w[14:0], b};
    endfunction

    assign rx_word = ins(sh_q, rx_bit);
    assign tx_pop  = ((st_q == SPP_IDLE) ||
                      (st_q == SPP_GAP && gap_cnt_q == 8'h00))
                     && en && !txq.empty && (master || sel_act);
    assign txq.rd  = tx_pop;
    assign done_ev = (st_q == SPP_SHIFT) && sel_act && smp &&
                     (bit_q == len - 5'h01);
    assign rx_push = done_ev && !rxq.full;
    assign ovr_ev  = done_ev && rxq.full;
    assign rxq.wr  = rx_push;
    // right-align received bits
    assign rxq.wdata = rx_word & ((16'h0001 << len) - 16'h0001);

    // sequencer with inter-word gap msb-first shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= SPP_IDLE;
            sh_q      <= 16'h0000;
            bit_q     <= 5'h00;
            phase_q   <= 1'b0;
            gap_cnt_q <= 8'h00;
        end else begin
            case (st_q)
                SPP_IDLE, SPP_GAP: begin
                    if (st_q == SPP_GAP && gap_cnt_q != 8'h00) begin
                        gap_cnt_q <= gap_cnt_q - 8'h01;
                    end
                    if (tx_pop) begin
                        sh_q    <= txq.rdata;
                        bit_q   <= 5'h00;
                        phase_q <= 1'b0;
                        st_q    <= SPP_SHIFT;
                    end else if (st_q == SPP_GAP && gap_cnt_q == 8'h00) begin
                        st_q <= SPP_IDLE;
                    end
                end
                SPP_SHIFT: begin
                    if (!en || (!master && slave_select_pin_i)) begin
                        st_q <= SPP_IDLE;
                    end else if (smp) begin
                        sh_q    <= rx_word;
                        phase_q <= 1'b1;
                        if (bit_q == len - 5'h01) begin
                            gap_cnt_q <= gap_q;
                            st_q      <= SPP_GAP;
                        end else begin
                            bit_q <= bit_q + 5'h01;
                        end
                    end else if (lau) begin
                        phase_q <= 1'b0;
                    end
                end
                default: st_q <= SPP_IDLE;
            endcase
        end
    end

    // sticky status; a read clears only the bits it reported, set wins
    assign st_set = {5'h00, ovr_ev, txq.empty, rx_push};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= 8'h00;
            irq    <= 1'b0;
        end else begin
            if (ap && rd_acc && idx == spp_pkg::IDX_STATUS) begin
                stat_q <= (stat_q & ~prdata[7:0]) | st_set;
            end else begin
                stat_q <= stat_q | st_set;
            end
            irq <= |(stat_q & mask_q);
        end
    end

    // pin drivers; released when disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock_pin_o           <= 1'b0;
            serial_clock_pin_oe_b        <= 1'b1;
            slave_in_master_out_pin_o    <= 1'b0;
            slave_in_master_out_pin_oe_b <= 1'b1;
            slave_out_master_in_pin_o    <= 1'b0;
            slave_out_master_in_pin_oe_b <= 1'b1;
            slave_select_pin_o           <= 1'b1;
            slave_select_pin_oe_b        <= 1'b1;
        end else begin
            serial_clock_pin_o           <= sck_q;
            serial_clock_pin_oe_b        <= !(en && master);
            slave_in_master_out_pin_o    <= sh_q[15];
            slave_in_master_out_pin_oe_b <= !(en && master && txen &&
                                             !(three && !txen));
            slave_out_master_in_pin_o    <= sh_q[15];
            // slave drives only while selected and transmit on
            slave_out_master_in_pin_oe_b <= !(en && !master && txen &&
                                             !slave_select_pin_i);
            slave_select_pin_o           <= !(st_q == SPP_SHIFT);
            slave_select_pin_oe_b        <= !(en && master);
        end
    end
endmodule // spp_top

// >>> tb/spp_props.sv
`timescale 1ns/100ps
module spp_props (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe_b,
    input wire logic        slave_out_master_in_pin_oe_b,
    input wire logic        slave_select_pin_oe_b,
    input wire logic        slave_select_pin_i
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_next: assert property (s_setup |=> s_access)
        else $error("no answer one cycle after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    a_upper_zero: assert property (pready && !pwrite
        |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_err_frame: assert property (pready |-> pslverr ==
        (paddr < spp_pkg::FRAME_BASE ||
         paddr > spp_pkg::FRAME_BASE + 16'h003F))
        else $error("error flag does not match address frame");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error flag outside answer");
    a_clock_half: assert property (!serial_clock_pin_oe_b
        && $changed(serial_clock_pin_o) |=> $stable(serial_clock_pin_o))
        else $error("serial clock half period below two cycles");
    a_select_slave: assert property (slave_select_pin_i [*2]
        |-> slave_out_master_in_pin_oe_b)
        else $error("slave data driven while not selected");
    a_master_clock: assert property (!slave_select_pin_oe_b
        |-> !serial_clock_pin_oe_b)
        else $error("select driven without driving clock");
endmodule // spp_props
bind spp_top spp_props u_props (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_b(serial_clock_pin_oe_b),
    .slave_out_master_in_pin_oe_b(slave_out_master_in_pin_oe_b),
    .slave_select_pin_oe_b(slave_select_pin_oe_b),
    .slave_select_pin_i(slave_select_pin_i));

// >>> tb/spp_peer.sv
`timescale 1ns/100ps
module spp_peer (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        ss_b,
    input  wire logic        pol,
    input  wire logic        pha,
    input  wire logic [15:0] tx_word,
    output logic             miso,
    output logic [15:0]      rx_word
);
    logic [15:0] sh_q;
    logic        sclk_q;
    logic        ss_q;
    logic        lead;
    logic        trail;
    assign lead  = (sclk != sclk_q) && (sclk != pol);
    assign trail = (sclk != sclk_q) && (sclk == pol);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q  <= 1'b0;
            ss_q    <= 1'b1;
            sh_q    <= '0;
            miso    <= 1'b0;
            rx_word <= '0;
        end else begin
            sclk_q <= sclk;
            ss_q   <= ss_b;
            if (ss_q && ss_b) begin
                miso <= ~miso; // released line keeps moving
            end else if (ss_q) begin
                rx_word <= '0;
                sh_q    <= pha ? tx_word << 1 : tx_word;
                miso    <= pha ? tx_word[15] : ~miso;
            end else begin
                if (pha ? trail : lead) begin
                    miso <= sh_q[15];
                    sh_q <= sh_q << 1;
                end
                if (pha ? lead : trail) begin
                    rx_word <= {rx_word[14:0], mosi};
                end
            end
        end
    end
endmodule // spp_peer

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    localparam logic [6:0]  RATE_T [5] = '{7'h02, 7'h06, 7'h03, 7'h7F, 7'h00};
    localparam logic [15:0] PER_T  [5] = '{16'h4, 16'h7, 16'h4, 16'h80, 16'h4};
    localparam int          LEN_T  [5] = '{16, 5, 2, 8, 1};
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic [15:0] paddr, peer_tx, peer_rx, period;
    logic [31:0] pwdata, prdata, rd_v;
    logic        err_v, sck_o, sck_oe_b, mo_o, mo_oe_b, mi_o, mi_oe_b;
    logic        ss_o, ss_oe_b, sck_w, mo_w, mi_w, ss_w, peer_mi, pol, pha;
    logic        sck_q;
    int          failures, n_tests, cyc, last_rise;
    assign sck_w = sck_oe_b ? pol : sck_o;
    assign mo_w  = mo_oe_b ? ~mo_o : mo_o;
    assign mi_w  = mi_oe_b ? peer_mi : mi_o;
    assign ss_w  = ss_oe_b ? 1'b1 : ss_o; // select has a pull-up
    spp_top DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_b(sck_oe_b), .slave_in_master_out_pin_i(mo_w),
        .slave_in_master_out_pin_o(mo_o),
        .slave_in_master_out_pin_oe_b(mo_oe_b),
        .slave_out_master_in_pin_i(mi_w), .slave_out_master_in_pin_o(mi_o),
        .slave_out_master_in_pin_oe_b(mi_oe_b), .slave_select_pin_i(ss_w),
        .slave_select_pin_o(ss_o), .slave_select_pin_oe_b(ss_oe_b));
    spp_peer u_peer (.clk(clk), .rst_b(rst_b), .sclk(sck_w), .mosi(mo_w),
        .ss_b(ss_w), .pol(pol), .pha(pha), .tx_word(peer_tx), .miso(peer_mi),
        .rx_word(peer_rx));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bit period measured between leading clock edges within a word
    always @(posedge clk) begin
        cyc   <= cyc + 1;
        sck_q <= sck_o;
        if (!sck_oe_b && sck_o != pol && sck_q == pol) begin
            period    <= 16'(cyc - last_rise);
            last_rise <= cyc;
        end
        if (cyc == 20000) begin
            failures++;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end
    function automatic logic [15:0] ra(input logic [3:0] idx);
        return spp_pkg::FRAME_BASE + {10'h000, idx, 2'b00};
    endfunction
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd_v = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input int i);
        logic [15:0] w, pw, ep, ew;
        logic [7:0]  lo;
        int          len, k;
        len = LEN_T[i];
        w = 16'hC3A5 ^ 16'(i * 16'h1357);
        pw = ~w + 16'(i);
        // transfer 4 has transmit off: the released line shows the inverse
        ep = ((i == 4) ? ~w : w) >> (16 - len);
        // transfer 1 runs three-wire: the master hears its own out line
        ew = ((i == 1) ? w : pw) >> (16 - len);
        pol <= i[1];
        pha <= i[0];
        peer_tx <= pw;
        apb(1'b1, ra(spp_pkg::IDX_RATE), {25'h0, RATE_T[i]});
        apb(1'b1, ra(spp_pkg::IDX_MASK), (i == 3) ? 32'h0 : 32'h1);
        apb(1'b1, ra(spp_pkg::IDX_CONFIG),
            {24'h0, 1'b1, i[1], 2'b00, 4'(len - 1)});
        apb(1'b1, ra(spp_pkg::IDX_CONTROL),
            {28'h0, i == 1, i[0], i != 4, 1'b1});
        apb(1'b1, ra(spp_pkg::IDX_TXLO), {24'h0, w[7:0]});
        apb(1'b1, ra(spp_pkg::IDX_TXHI), {24'h0, w[15:8]});
        k = 0;
        if (i != 3) begin
            while (irq !== 1'b1 && k < 3000) begin
                @(posedge clk);
                k++;
            end
            `CHK(irq, 1'b1)
            apb(1'b0, ra(spp_pkg::IDX_STATUS), 32'h0);
            `CHK(rd_v[0], 1'b1)
            repeat (2) @(posedge clk);
            `CHK(irq, 1'b0)
        end else begin
            rd_v = '0;
            while (rd_v[0] !== 1'b1 && k < 3000) begin
                apb(1'b0, ra(spp_pkg::IDX_STATUS), 32'h0);
                k++;
            end
            `CHK(rd_v[0], 1'b1)
            `CHK(irq, 1'b0)
        end
        apb(1'b0, ra(spp_pkg::IDX_RXLO), 32'h0);
        lo = rd_v[7:0];
        apb(1'b0, ra(spp_pkg::IDX_RXHI), 32'h0);
        `CHK({rd_v[7:0], lo}, ew)
        `CHK(peer_rx, ep)
        if (len > 1) `CHK(period, PER_T[i])
        apb(1'b1, ra(spp_pkg::IDX_CONTROL), 32'h0);
        repeat (2) @(posedge clk);
        `CHK({sck_oe_b, mo_oe_b, mi_oe_b, ss_oe_b}, 4'hF)
        $display("test transfer %0d done", i);
    endtask
    initial begin
        {psel, penable, pwrite, pol, pha, sck_q} = '0;
        paddr = '0;
        pwdata = '0;
        peer_tx = '0;
        period = '0;
        {failures, n_tests, cyc, last_rise} = '0;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, ra(spp_pkg::IDX_CONFIG), 32'h0);
        `CHK(rd_v, 32'h0000000F)
        apb(1'b0, ra(spp_pkg::IDX_RATE), 32'h0);
        `CHK(rd_v, 32'h00000003)
        apb(1'b1, ra(spp_pkg::IDX_CONFIG), 32'hFFFFFFC7);
        apb(1'b0, ra(spp_pkg::IDX_CONFIG), 32'h0);
        `CHK(rd_v, 32'h000000C7)
        apb(1'b0, spp_pkg::FRAME_BASE + 16'h0040, 32'h0);
        `CHK({err_v, rd_v}, {1'b1, 32'h0})
        $display("test registers done");
        for (int i = 0; i < 5; i++) xfer(i);
        end_sim();
    end
endmodule // tb_top
